// file: core/acsq_top.v
// Channel sequencer, control capture and result word formatter
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`include "acsq_defines.vh"
module acsq_top #(
  parameter RES_BITS = `ACSQ_RES_BITS
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Serial pins
  input wire cs_n,
  input wire sclk,
  input wire din,
  output reg dout,
  output reg dout_oe,
  // Converter core
  output reg conv_start,
  output reg [2:0] mux_sel,
  output reg span_double,
  output reg [1:0] power_mode,
  input wire [11:0] conv_code,
  input wire conv_done
);

  // Pin levels after synchronisation
  wire cs_n_s;
  wire sclk_s;
  wire din_s;
  reg cs_n_d;
  reg sclk_d;
  wire cs_fall;
  wire cs_rise;
  wire sclk_fall;

  // Transfer state
  reg active;
  reg [4:0] bit_cnt;
  reg [15:0] in_sr;
  reg [15:0] out_word;

  // Control state
  reg enable;
  reg [2:0] channel_addr_bits;
  reg auto_cycle_bit;
  reg list_select_bit;
  reg range_sel;
  reg coding_sel;
  reg [1:0] mode;
  reg list_pending;
  reg list_fresh;
  reg [15:0] chan_list;
  reg [3:0] list_pos;
  reg [2:0] range_chan;
  reg [2:0] range_last;
  reg [2:0] conv_chan;
  reg [15:0] xfer_count;

  // Next-value terms
  reg [2:0] next_chan;
  wire [3:0] scan_cur;
  wire [3:0] scan_nxt;
  wire scan_found;
  reg [11:0] ctrl_word;
  wire wb_hit;

  // Keeps the top RES_BITS of the code, low bits forced to zero
  function [11:0] acsq_format;
    input [11:0] code;
    input twos;
    reg [11:0] mask;
    begin
      mask = 12'hFFF << (12 - RES_BITS);
      acsq_format = code & mask;
      if (twos) begin
        acsq_format[11] = ~code[11];
      end
    end
  endfunction

  // List slot to channel number
  function [2:0] acsq_slot_chan;
    input [3:0] slot;
    begin
      acsq_slot_chan = slot[2:0];
    end
  endfunction

  // Pin synchronisers
  acsq_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clock(clock),
    .rst(rst),
    .pin(cs_n),
    .level(cs_n_s)
  );
  acsq_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .clock(clock),
    .rst(rst),
    .pin(sclk),
    .level(sclk_s)
  );
  acsq_sync #(.RST_VAL(1'b0)) u_sync_din (
    .clock(clock),
    .rst(rst),
    .pin(din),
    .level(din_s)
  );

  // List slot search
  acsq_list_scan u_scan (
    .list(chan_list),
    .cur(scan_cur),
    .nxt(scan_nxt),
    .found(scan_found)
  );

  // Fresh list searches from before slot 0
  assign scan_cur = list_fresh ? 4'hF : list_pos;

  // Edge detect on synchronised levels
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  assign cs_fall = cs_n_d & ~cs_n_s & enable;
  assign cs_rise = ~cs_n_d & cs_n_s;
  assign sclk_fall = sclk_d & ~sclk_s & active;

  // Channel for the conversion starting now
  always @* begin
    case (mode)
      `ACSQ_MODE_LIST: begin
        next_chan = scan_found ? acsq_slot_chan(scan_nxt)
                               : channel_addr_bits;
      end
      `ACSQ_MODE_RANGE: begin
        next_chan = range_chan;
      end
      default: begin
        next_chan = channel_addr_bits;
      end
    endcase
  end

  // Serial transfer: shift in, shift out, start conversion
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
      bit_cnt <= 5'h00;
      in_sr <= 16'h0000;
      out_word <= 16'h0000;
      dout <= 1'b0;
      dout_oe <= 1'b0;
      conv_start <= 1'b0;
      mux_sel <= 3'h0;
      conv_chan <= 3'h0;
      xfer_count <= 16'h0000;
      ctrl_word <= 12'h000;
    end else begin
      conv_start <= 1'b0;
      if (cs_fall) begin
        active <= 1'b1;
        bit_cnt <= 5'h00;
        conv_start <= 1'b1;
        mux_sel <= next_chan;
        conv_chan <= next_chan;
        out_word <= {1'b0, next_chan, 12'h000};
        dout <= 1'b0;
        dout_oe <= 1'b1;
        xfer_count <= xfer_count + 16'h0001;
      end else if (cs_rise) begin
        active <= 1'b0;
        dout_oe <= 1'b0;
        dout <= 1'b0;
      end else if (sclk_fall) begin
        in_sr <= {in_sr[14:0], din_s};
        bit_cnt <= bit_cnt + 5'h01;
        ctrl_word <= (bit_cnt == 5'h0B) ? {in_sr[10:0], din_s} : ctrl_word;
        if (bit_cnt >= 5'h0F) begin
          dout_oe <= 1'b0;
          dout <= 1'b0;
        end else begin
          dout <= out_word[4'hE - bit_cnt[3:0]];
        end
      end
      if (conv_done && active) begin
        out_word[11:0] <= acsq_format(conv_code, coding_sel);
      end
    end
  end

  // Control word, list load and sequence stepping
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      channel_addr_bits <= 3'h0;
      auto_cycle_bit <= 1'b0;
      list_select_bit <= 1'b0;
      range_sel <= `ACSQ_RANGE_RST;
      coding_sel <= `ACSQ_CODING_RST;
      power_mode <= `ACSQ_PM_RST;
      span_double <= ~`ACSQ_RANGE_RST;
      mode <= `ACSQ_MODE_SINGLE;
      list_pending <= 1'b0;
      list_fresh <= 1'b0;
      chan_list <= 16'h0000;
      list_pos <= 4'h0;
      range_chan <= 3'h0;
      range_last <= 3'h0;
    end else if (cs_fall) begin
      // Advance the list or range position after each conversion start
      if (mode == `ACSQ_MODE_LIST) begin
        list_fresh <= 1'b0;
        list_pos <= scan_nxt;
      end else if (mode == `ACSQ_MODE_RANGE) begin
        if (range_chan == range_last) begin
          range_chan <= 3'h0;
        end else begin
          range_chan <= range_chan + 3'h1;
        end
      end
    end else if (cs_rise && active) begin
      if (list_pending) begin
        if (bit_cnt >= 5'h10) begin
          chan_list <= in_sr;
          list_pending <= 1'b0;
          list_fresh <= 1'b1;
          mode <= `ACSQ_MODE_LIST;
        end
      end else if (bit_cnt >= 5'h0C && ctrl_word[`ACSQ_CW_WRITE]) begin
        channel_addr_bits <= ctrl_word[`ACSQ_CW_ADDR_HI:`ACSQ_CW_ADDR_LO];
        auto_cycle_bit <= ctrl_word[`ACSQ_CW_AUTO];
        list_select_bit <= ctrl_word[`ACSQ_CW_LIST];
        power_mode <= ctrl_word[`ACSQ_CW_PM_HI:`ACSQ_CW_PM_LO];
        range_sel <= ctrl_word[`ACSQ_CW_RANGE];
        span_double <= ~ctrl_word[`ACSQ_CW_RANGE];
        coding_sel <= ctrl_word[`ACSQ_CW_CODING];
        case ({ctrl_word[`ACSQ_CW_AUTO], ctrl_word[`ACSQ_CW_LIST]})
          2'b10: begin
            mode <= mode;
          end
          2'b01: begin
            mode <= `ACSQ_MODE_SINGLE;
            list_pending <= 1'b1;
          end
          2'b11: begin
            mode <= `ACSQ_MODE_RANGE;
            range_chan <= 3'h0;
            range_last <= ctrl_word[`ACSQ_CW_ADDR_HI:`ACSQ_CW_ADDR_LO];
          end
          default: begin
            mode <= `ACSQ_MODE_SINGLE;
          end
        endcase
      end
    end
  end

  // Wishbone slave: one wait state, ack drops after one cycle
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      enable <= `ACSQ_ENABLE_RST;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i &&
          wb_adr_i == `ACSQ_REG_ENABLE && wb_sel_i[0]) begin
        enable <= wb_dat_i[0];
      end
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          `ACSQ_REG_ENABLE: begin
            wb_dat_o <= {31'h00000000, enable};
          end
          `ACSQ_REG_STATUS: begin
            wb_dat_o <= {10'h000, list_pending, list_fresh, mode,
                         range_last, range_chan, conv_chan,
                         power_mode, range_sel, coding_sel,
                         auto_cycle_bit, list_select_bit,
                         channel_addr_bits};
          end
          `ACSQ_REG_LIST: begin
            wb_dat_o <= {12'h000, list_pos, chan_list};
          end
          `ACSQ_REG_WORD: begin
            wb_dat_o <= {16'h0000, out_word};
          end
          `ACSQ_REG_COUNT: begin
            wb_dat_o <= {16'h0000, xfer_count};
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end else if (!wb_hit) begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

endmodule // acsq_top

// file: common/acsq_defines.vh
// Constants for the converter channel sequencer and word formatter
`ifndef ACSQ_DEFINES_VH
`define ACSQ_DEFINES_VH

// Serial word geometry
`define ACSQ_WORD_BITS 16
`define ACSQ_CTRL_BITS 12
`define ACSQ_DATA_BITS 12

// Control word field positions (first bit shifted in is bit 11)
`define ACSQ_CW_WRITE 11
`define ACSQ_CW_AUTO 10
`define ACSQ_CW_ADDR_HI 8
`define ACSQ_CW_ADDR_LO 6
`define ACSQ_CW_PM_HI 5
`define ACSQ_CW_PM_LO 4
`define ACSQ_CW_LIST 3
`define ACSQ_CW_RANGE 1
`define ACSQ_CW_CODING 0

// Steps across the reference span per resolution
`define ACSQ_STEPS_8 256
`define ACSQ_STEPS_10 1024
`define ACSQ_STEPS_12 4096
`define ACSQ_RES_BITS 12

// Wishbone register byte offsets
`define ACSQ_REG_ENABLE 8'h00
`define ACSQ_REG_STATUS 8'h04
`define ACSQ_REG_LIST 8'h08
`define ACSQ_REG_WORD 8'h0C
`define ACSQ_REG_COUNT 8'h10

// Reset values
`define ACSQ_ENABLE_RST 1'b1
`define ACSQ_RANGE_RST 1'b1
`define ACSQ_CODING_RST 1'b1
`define ACSQ_PM_RST 2'h3

// Sequencing modes
`define ACSQ_MODE_SINGLE 2'h0
`define ACSQ_MODE_LIST 2'h1
`define ACSQ_MODE_RANGE 2'h2

`endif

// file: core/acsq_sync.v
// Two flip-flop synchroniser for one pin level
module acsq_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Level in and out
  input wire pin,
  output reg level
);

  reg stage1;

  // Stage one is read only by stage two
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= RST_VAL;
      level <= RST_VAL;
    end else begin
      stage1 <= pin;
      level <= stage1;
    end
  end

endmodule // acsq_sync

// file: core/acsq_list_scan.v
// Finds the next enabled slot of the 16-slot channel list
module acsq_list_scan (
  // List and current slot
  input wire [15:0] list,
  input wire [3:0] cur,
  // Next enabled slot after cur, cyclic
  output reg [3:0] nxt,
  output reg found
);

  integer i;
  reg [3:0] slot;

  // Slot 0 is list bit 15; first hit upward wins
  always @* begin
    nxt = cur;
    found = 1'b0;
    slot = 4'h0;
    for (i = 16; i >= 1; i = i - 1) begin
      slot = cur + i[3:0];
      if (list[4'hF - slot]) begin
        nxt = slot;
        found = 1'b1;
      end
    end
  end

endmodule // acsq_list_scan

// file: verif/acsq_top_asserts.sv
// Port checks for the sequencer top
module acsq_top_asserts (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Serial and converter
  input wire cs_n,
  input wire dout,
  input wire dout_oe,
  input wire conv_start,
  input wire [2:0] mux_sel,
  input wire span_double
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Chip select parked high long enough to clear the pipe
  sequence s_idle;
    cs_n [*6];
  endsequence
  // Frame opening: driving, leading zero
  sequence s_open;
    dout_oe && !dout;
  endsequence
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_start_open: assert property (conv_start |-> s_open)
    else $error("frame not opened by leading zero");
  a_oe_start: assert property ($rose(dout_oe) |-> conv_start)
    else $error("output driven without a conversion");
  a_mux_hold: assert property (dout_oe && $past(dout_oe) |-> $stable(mux_sel))
    else $error("channel moved inside a frame");
  a_idle_quiet: assert property (s_idle |-> !dout_oe && !conv_start)
    else $error("activity without a frame");
  a_span_idle: assert property ($changed(span_double) |-> cs_n)
    else $error("span changed inside a frame");
endmodule // acsq_top_asserts

// file: verif/acsq_host.sv
// Host serial port model
module acsq_host (
  // Clock
  input wire clock,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire dout
);
  timeunit 1ns;
  timeprecision 1ps;
  // Frame off, serial clock parked high
  initial begin
    cs_n = 1'h1;
    sclk = 1'h1;
    din = 1'h0;
  end
  // One frame, MSB first both ways, half period four clocks
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    int i;
    @(posedge clock);
    cs_n <= 1'h0;
    repeat (8) @(posedge clock);
    for (i = 15; i >= 0; i--) begin
      din <= w[i];
      repeat (4) @(posedge clock);
      r[i] = dout;
      sclk <= 1'h0;
      repeat (4) @(posedge clock);
      sclk <= 1'h1;
    end
    repeat (4) @(posedge clock);
    cs_n <= 1'h1;
    repeat (12) @(posedge clock);
  endtask
endmodule // acsq_host

// file: verif/acsq_top_tb.sv
// Bench for the sequencer top
`include "acsq_defines.vh"
module acsq_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, cs_n, sclk, din, dout, dout_oe, conv_start, span_double;
  logic [2:0] mux_sel;
  logic [1:0] power_mode;
  logic [1:0] st = 2'h0;
  logic [11:0] conv_code = 12'h000;
  logic conv_done = 1'h0;
  logic twos = 1'h1;
  int errors = 0;
  int comparisons = 0;
  always #10 clock = ~clock;
  acsq_top acsq_top_inst (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe(dout_oe), .conv_start(conv_start), .mux_sel(mux_sel),
    .span_double(span_double), .power_mode(power_mode), .conv_code(conv_code),
    .conv_done(conv_done));
  acsq_host acsq_host_inst (.clock(clock), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
  // Converter model: result tagged by channel three cycles after start
  always @(posedge clock) begin
    st <= {st[0], conv_start};
    conv_done <= st[1];
    if (st[1]) begin
      conv_code <= {mux_sel, 9'h0A5};
    end
  end
  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("[FAIL] %0t bus timeout", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  // Control word: mode is auto and list bits, power kept normal
  function automatic logic [15:0] cw(input logic [1:0] m, input logic [2:0] a,
      input logic rg, input logic cd);
    return {1'h1, m[1], 1'h0, a, 2'h3, m[0], 1'h0, rg, cd, 4'h0};
  endfunction
  // One frame, judged against channel and current coding
  task automatic fr(input logic [15:0] w, input logic [2:0] ch);
    logic [15:0] r;
    acsq_host_inst.xfer(w, r);
    chk_word(r, {1'h0, ch, {ch, 9'h0A5} ^ {twos, 11'h000}});
  endtask
  task t_regs();
    logic [31:0] q;
    logic [15:0] r;
    wb(1'h0, `ACSQ_REG_ENABLE, 32'h0, q);
    chk_val(q, 32'h1);
    wb(1'h1, 8'h20, 32'hFFFFFFFF, q);
    wb(1'h0, 8'h20, 32'h0, q);
    chk_val(q, 32'h0);
    wb(1'h1, `ACSQ_REG_ENABLE, 32'h0, q);
    wb(1'h0, `ACSQ_REG_ENABLE, 32'h0, q);
    chk_val(q, 32'h0);
    wb(1'h0, `ACSQ_REG_COUNT, 32'h0, q);
    chk_val(q, 32'h0);
    acsq_host_inst.xfer(16'h0, r);
    chk_word(r, 16'h0000);
    wb(1'h0, `ACSQ_REG_COUNT, 32'h0, q);
    chk_val(q, 32'h0);
    wb(1'h1, `ACSQ_REG_ENABLE, 32'h1, q);
    $display("t_regs done");
  endtask
  task t_single();
    int c;
    logic [31:0] q;
    logic [15:0] r;
    for (c = 0; c < 8; c++) begin
      acsq_host_inst.xfer(cw(2'h0, c[2:0], 1'h1, c[0]), r);
      twos = c[0];
      fr(16'h0, c[2:0]);
    end
    fr(16'h7FF0, 3'h7);
    fr(cw(2'h0, 3'h7, 1'h0, 1'h1), 3'h7);
    chk_val({31'h0, span_double}, 32'h1);
    fr(cw(2'h0, 3'h7, 1'h1, 1'h0), 3'h7);
    twos = 1'h0;
    chk_val({31'h0, span_double}, 32'h0);
    chk_val({30'h0, power_mode}, 32'h3);
    wb(1'h0, `ACSQ_REG_WORD, 32'h0, q);
    chk_val(q, {16'h0, 1'h0, 3'h7, {3'h7, 9'h0A5} ^ 12'h800});
    $display("t_single done");
  endtask
  task t_list();
    int i;
    logic [15:0] r;
    logic [2:0] sq [6];
    logic [31:0] q;
    sq = '{3'h1, 3'h4, 3'h6, 3'h2, 3'h1, 3'h4};
    fr(cw(2'h1, 3'h0, 1'h1, 1'h0), 3'h7);
    acsq_host_inst.xfer(16'h4A20, r);
    wb(1'h0, `ACSQ_REG_LIST, 32'h0, q);
    chk_val({16'h0, q[15:0]}, 32'h4A20);
    for (i = 0; i < 6; i++) begin
      fr(16'h0, sq[i]);
    end
    fr(cw(2'h2, 3'h0, 1'h1, 1'h1), 3'h6);
    twos = 1'h1;
    fr(16'h0, 3'h2);
    fr(cw(2'h0, 3'h3, 1'h1, 1'h0), 3'h1);
    twos = 1'h0;
    fr(16'h0, 3'h3);
    $display("t_list done");
  endtask
  task t_range();
    int i;
    fr(cw(2'h3, 3'h2, 1'h1, 1'h0), 3'h3);
    for (i = 0; i < 5; i++) begin
      fr(16'h0, 3'(i % 3));
    end
    fr(cw(2'h2, 3'h0, 1'h1, 1'h0), 3'h2);
    fr(16'h0, 3'h0);
    fr(cw(2'h0, 3'h0, 1'h1, 1'h0), 3'h1);
    fr(16'h0, 3'h0);
    $display("t_range done");
  endtask
  task complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    repeat (4) @(posedge clock);
    t_regs();
    t_single();
    t_list();
    t_range();
    complete_run();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    complete_run();
  end
endmodule // acsq_top_tb
bind acsq_top acsq_top_asserts acsq_top_asserts_inst (.clock(clock), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe), .conv_start(conv_start),
  .mux_sel(mux_sel), .span_double(span_double));
